// ### verilog/spimsp_top.sv
/*
  spimsp_top: serial peripheral port, master or slave, with double-buffered
  transmit and receive paths, bit-rate divider and pin control.
  assumes pin inputs are synchronous to i_clk and the register port follows
  the one-cycle strobe protocol with read data in the following cycle.
*/
// How it works
// RULE_01: bit-rate path first divides the bus clock by a prescale of one to eight.
// RULE_02: prescaled clock is then divided by a power of two, 2 to 256.
// RULE_03: free shifter takes the queued byte, transmit-empty sets, transfer starts.
// RULE_04: data is sampled on one serial edge and changed half a period later.
// RULE_05: after eight clocks the byte moves to the receive buffer, receive-full sets.
// RULE_06: a byte waiting at transfer end loads at once and starts the next.
// RULE_07: most significant bit first, least first when bit order is set.
// RULE_08: external master holds select low for the whole transfer.
// RULE_09: with phase 0 select returns high between bytes; phase 1 may stay low.
// RULE_10: one byte queues while another shifts; one received byte is held.
// RULE_11: byte completing while receive buffer is full is dropped, no flag.
// RULE_12: phase 0 slave drives its first bit as soon as select goes low.
// RULE_13: disabled port releases all four pins to ordinary port control.
// RULE_14: clock pin is an input in slave mode and an output in master mode.
// RULE_15: master-out pin: master output, slave input, master single-wire pin.
// RULE_16: master-in pin: master input, slave output, slave single-wire pin.
// RULE_17: select pin: slave select input; master fault input or select output.
// RULE_18: data read gives receive buffer; write fills transmit buffer, starts master.
// RULE_19: host writes only when transmit-empty and reads before the next byte ends.
// RULE_20: after reset disabled, buffers empty, transmit-empty set, receive-full clear.
`timescale 1ns/1ns
module spimsp_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [spimsp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [spimsp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [spimsp_pkg::DATA_W-1:0] o_rdata,
  // serial pins
  input wire spimsp_pkg::spimsp_pins_t i_pin,
  output spimsp_pkg::spimsp_pins_t o_pin,
  output spimsp_pkg::spimsp_pins_t o_pin_oe_n,
  output spimsp_pkg::spimsp_pins_t o_pin_own
);
  import spimsp_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] baud_q;
  logic [7:0] tx_buf_q;
  logic [7:0] rx_buf_q;
  logic tx_empty_q;
  logic rx_full_q;
  logic fault_q;
  spimsp_state_t state_q;
  spimsp_state_t state_d;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic msample_q;
  logic sh_full_q;
  logic [3:0] edge_q;
  logic sck_in_q;
  logic tick;
  spimsp_pins_t pin_q;
  spimsp_pins_t oe_n_q;
  spimsp_pins_t own_q;
  spimsp_pins_t pin_d;
  spimsp_pins_t oe_n_d;
  spimsp_pins_t own_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] stat_w;

  // field decode
  wire en = ctrl_q[CTL_EN];
  wire master = en & ctrl_q[CTL_MST];
  wire slave = en & ~ctrl_q[CTL_MST];
  wire cpol = ctrl_q[CTL_CPOL];
  wire clock_phase = ctrl_q[CTL_CLOCK_PHASE];
  wire lsbf = ctrl_q[CTL_LSBF];
  wire select_output_enable = ctrl_q[CTL_SELECT_OUTPUT_ENABLE];
  wire flt_en = mode_q[MOD_FLT];
  wire one_wire = mode_q[MOD_1W];
  wire one_wire_oe = mode_q[MOD_1WOE];
  wire [2:0] rate = baud_q[BAUD_RATE_LO +: 3];
  wire [2:0] presc = baud_q[BAUD_PRE_LO +: 3];

  // register port decode
  wire wr_data = i_wr & (i_addr == ADDR_DATA);
  wire wr_ctrl = i_wr & (i_addr == ADDR_CTRL);
  wire wr_mode = i_wr & (i_addr == ADDR_MODE);
  wire wr_baud = i_wr & (i_addr == ADDR_BAUD);
  wire rd_data = i_rd & (i_addr == ADDR_DATA);
  wire rd_stat = i_rd & (i_addr == ADDR_STAT);

  // select and clock edges seen from the pins
  wire ss_low = ~i_pin.ss;
  wire slave_sel = slave & ss_low;
  wire sck_edge = slave_sel & (i_pin.sck != sck_in_q);
  // fault: another master pulls our select pin low while we are master
  wire fault_ev = master & flt_en & ~select_output_enable & ss_low; // see RULE_17
  wire shifting = state_q == ST_SHIFT;
  wire done = state_q == ST_DONE;
  // an external master raising select mid-byte aborts it
  wire slave_abort = slave & ~ss_low & shifting; // see RULE_08 see RULE_09

  // serial edge events; odd edge counts are trailing edges
  wire edge_ev = master ? (tick & shifting) : (sck_edge & ~done);
  wire leading = ~edge_q[0];
  // phase 1 changes data on leading edges, phase 0 on trailing ones
  wire shift_ev = edge_ev & (clock_phase ? (leading & (edge_q != 4'h0)) : ~leading); // see RULE_04
  wire sample_ev = edge_ev & (clock_phase ? ~leading : leading); // see RULE_04
  wire last_ev = edge_ev & (edge_q == EDGE_LAST); // see RULE_05

  // data direction follows mode and single-wire selection
  wire in_bit = (master ^ one_wire) ? i_pin.miso : i_pin.mosi; // see RULE_15 see RULE_16
  wire out_bit = lsbf ? tx_sh_q[0] : tx_sh_q[7]; // see RULE_07
  wire [7:0] rx_shifted = lsbf ? {in_bit, rx_sh_q[7:1]} : {rx_sh_q[6:0], in_bit}; // see RULE_07
  wire [7:0] tx_shifted = lsbf ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
  // the master's clock pin lags its edge events by a cycle; sampling at the pin edge keeps
  // a one-clock half period from catching the bit the partner is just changing
  wire rx_step = master ? msample_q : sample_ev; // see RULE_04
  wire [7:0] rx_final = rx_step ? rx_shifted : rx_sh_q;

  // shifter takes the queued byte when free or right at the end of a byte
  wire load = en & ~tx_empty_q & (~sh_full_q | done); // see RULE_03 see RULE_06 see RULE_10
  // a read in the same cycle frees the buffer, so the new byte is kept
  wire rx_take = done & (~rx_full_q | rd_data); // see RULE_11

  // pin drive decisions
  wire drive_sck = master; // see RULE_14
  wire drive_mosi = master & (~one_wire | one_wire_oe); // see RULE_15
  wire drive_miso = slave_sel & (~one_wire | one_wire_oe); // see RULE_16 see RULE_12
  wire drive_ss = master & flt_en & select_output_enable; // see RULE_17

  spimsp_baud_div #(
    .W(DIV_W)
  ) u_div (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(master & shifting),
    .i_presc(presc),
    .i_rate(rate),
    .o_tick(tick)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (master & (sh_full_q | load)) begin
          state_d = ST_SHIFT; // see RULE_03
        end else if (sck_edge) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (last_ev) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = (master & load) ? ST_SHIFT : ST_IDLE; // see RULE_06
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (~en | fault_ev | slave_abort) begin
      state_d = ST_IDLE;
    end
  end

  // status and read mux
  always_comb begin
    stat_w = 8'h00;
    stat_w[STAT_RXF] = rx_full_q;
    stat_w[STAT_TXE] = tx_empty_q;
    stat_w[STAT_FLT] = fault_q;
    rdata_d = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_DATA: rdata_d = rx_buf_q; // see RULE_18
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_MODE: rdata_d = mode_q;
        ADDR_BAUD: rdata_d = baud_q;
        ADDR_STAT: rdata_d = stat_w;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // pins: idle clock level is cpol, select output low only while shifting
  assign pin_d = '{sck: cpol ^ edge_q[0], mosi: out_bit, miso: out_bit, ss: ~shifting};
  assign oe_n_d = '{sck: ~drive_sck, mosi: ~drive_mosi, miso: ~drive_miso, ss: ~drive_ss};
  // ownership drops to the port logic for unused pins and when disabled
  assign own_d = '{sck: en, mosi: en & ~(slave & one_wire), // see RULE_13
                   miso: en & ~(master & one_wire), ss: slave | (master & flt_en)};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST; // see RULE_20
      mode_q <= MODE_RST;
      baud_q <= BAUD_RST;
    end else begin
      if (wr_ctrl | fault_ev) begin
        // a fault forces the port out of master mode
        ctrl_q <= fault_ev ? (ctrl_q & ~(8'h01 << CTL_MST)) : i_wdata;
      end
      if (wr_mode) begin
        mode_q <= i_wdata;
      end
      if (wr_baud) begin
        baud_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_buf_q <= BYTE_RST;
      tx_empty_q <= 1'b1; // see RULE_20
    end else begin
      if (wr_data) begin
        tx_buf_q <= i_wdata; // see RULE_18
      end
      // a write in the load cycle queues a fresh byte, so it wins
      tx_empty_q <= ~wr_data & (tx_empty_q | load); // see RULE_03
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_buf_q <= BYTE_RST;
      rx_full_q <= 1'b0; // see RULE_20
      fault_q <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_buf_q <= rx_final; // see RULE_05
      end
      rx_full_q <= rx_take | (rx_full_q & ~rd_data);
      fault_q <= fault_ev | (fault_q & ~rd_stat);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_sh_q <= BYTE_RST;
      sh_full_q <= 1'b0;
    end else begin
      if (load) begin
        tx_sh_q <= tx_buf_q;
      end else if (shift_ev) begin
        tx_sh_q <= tx_shifted;
      end
      sh_full_q <= load | (sh_full_q & ~done & en);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_sh_q <= BYTE_RST;
      msample_q <= 1'b0;
      edge_q <= 4'h0;
      sck_in_q <= 1'b0;
      state_q <= ST_IDLE;
    end else begin
      if (rx_step) begin
        rx_sh_q <= rx_shifted;
      end
      msample_q <= master & sample_ev;
      edge_q <= (state_d == ST_IDLE) ? 4'h0 : edge_q + {3'h0, edge_ev};
      sck_in_q <= i_pin.sck;
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_q <= '0;
      oe_n_q <= '1;
      own_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
      own_q <= own_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_pin = pin_q;
  assign o_pin_oe_n = oe_n_q;
  assign o_pin_own = own_q;
  assign o_rdata = rdata_q;

  a_tx_load_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_03
    load && !wr_data |=> tx_empty_q && sh_full_q)
    else $error("queued byte did not move to shifter");

  a_rx_take_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_05
    done && !rx_full_q |=> rx_full_q && rx_buf_q == $past(rx_final))
    else $error("completed byte not placed in receive buffer");

  a_rx_overrun_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_11
    done && rx_full_q && !rd_data |=> rx_full_q && rx_buf_q == $past(rx_buf_q))
    else $error("overrun byte overwrote unread data");

  a_next_byte_start: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_06
    done && master && !tx_empty_q && !fault_ev && !wr_ctrl |=> shifting && tx_empty_q == !$past(wr_data))
    else $error("waiting byte did not start at once");

  a_pins_released: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_13
    !en |=> o_pin_oe_n == 4'hF && o_pin_own == 4'h0)
    else $error("disabled port still holds pins");

  a_sck_direction: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_14
    en |=> o_pin_oe_n.sck == !$past(master))
    else $error("clock pin direction wrong for mode");

  a_prescale_eight: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_01
    tick && presc == 3'h7 && rate == 3'h0 && !wr_baud |=> !tick [*7])
    else $error("prescale of eight ticks too early");

  a_rate_power_two: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_02
    tick && presc == 3'h0 && rate == 3'h3 && !wr_baud |=> !tick [*7])
    else $error("rate divider ticks too early");

  a_read_data_reg: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_18
    rd_data |=> o_rdata == $past(rx_buf_q))
    else $error("data read did not return receive buffer");

  a_phase0_first_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_12
    slave_sel && !clock_phase && !one_wire |=> !o_pin_oe_n.miso && o_pin.miso == $past(out_bit))
    else $error("phase 0 slave not driving first bit");

  a_msb_first_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_07
    load && !lsbf && !wr_ctrl |=> out_bit == $past(tx_buf_q[7]))
    else $error("first bit out is not the top bit");

  a_reset_values: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RULE_20
    $past(i_sys_rst) |-> tx_empty_q && !rx_full_q && !en && state_q == ST_IDLE)
    else $error("wrong state after reset");
endmodule

// ### shared/spimsp_pkg.sv
/*
  spimsp_pkg: register map, field positions, reset values, engine states and
  the pin bundle of the serial port.
  assumes an 8-bit register port with a 3-bit word address.
*/
package spimsp_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W = 11;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h4;

  // control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_MST = 1;
  localparam int CTL_CPOL = 2;
  localparam int CTL_CLOCK_PHASE = 3;
  localparam int CTL_LSBF = 4;
  localparam int CTL_SELECT_OUTPUT_ENABLE = 5;

  // pin mode register fields
  localparam int MOD_FLT = 0;
  localparam int MOD_1W = 1;
  localparam int MOD_1WOE = 2;

  // rate field in bits 2:0, prescale field in bits 6:4
  localparam int BAUD_RATE_LO = 0;
  localparam int BAUD_PRE_LO = 4;

  // status fields
  localparam int STAT_RXF = 7;
  localparam int STAT_TXE = 5;
  localparam int STAT_FLT = 4;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] BAUD_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

  // sixteen serial clock edges make one byte
  localparam logic [3:0] EDGE_LAST = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11
  } spimsp_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spimsp_pins_t;
endpackage

// ### verilog/spimsp_baud_div.sv
/*
  spimsp_baud_div: half-period tick generator for the master serial clock.
  assumes i_run drops between bytes, so every byte starts on a fresh count.
*/
`timescale 1ns/1ns
module spimsp_baud_div #(
  parameter int W = 11
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_run,
  input wire logic [2:0] i_presc,
  input wire logic [2:0] i_rate,
  // half-period pulse
  output logic o_tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // half period = prescale (1..8) times half of 2..256
  wire [W-1:0] half = W'({1'b0, i_presc} + 4'h1) << i_rate; // see RULE_01 see RULE_02

  assign o_tick = i_run & (cnt_q == half - W'(1));
  assign cnt_d = (~i_run | o_tick) ? '0 : cnt_q + W'(1);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### verification/spimsp_peer.sv
/*
  spimsp_peer: external serial slave facing the port in master mode,
  clock idle low, sample on rising and change on falling edge, msb first.
  assumes the pin levels given are the resolved wire levels.
*/
`timescale 1ns/1ns
module spimsp_peer (
  // pins seen by the peer
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  input wire logic [7:0] i_reply,
  // peer results
  output logic o_miso,
  output logic [7:0] o_rx,
  output int o_cnt
);
  logic [7:0] sh;
  logic [7:0] acc;
  int nbit;
  initial begin
    o_miso = 1'b1;
    o_rx = 8'h00;
    o_cnt = 0;
    sh = 8'h00;
    acc = 8'h00;
    nbit = 0;
  end
  // each byte sent is the reply xor the count of bytes seen so far
  always @(negedge i_ss_n) begin
    sh = i_reply ^ o_cnt[7:0];
    nbit = 0;
    o_miso = sh[7];
  end
  // released line flips so a stale bit is never mistaken for data
  always @(posedge i_ss_n) o_miso = ~o_miso;
  // the byte is whole at the eighth sampling edge: the master may raise select
  // together with its last clock edge
  always @(posedge i_sck) if (!i_ss_n) begin
    acc = {acc[6:0], i_mosi};
    nbit++;
    if (nbit == 8) begin
      o_rx = acc;
      o_cnt++;
      nbit = 0;
    end
  end
  always @(negedge i_sck) if (!i_ss_n) begin
    sh = {sh[6:0], 1'b0};
    o_miso = sh[7];
  end
endmodule

// ### verification/tb_top.sv
/*
  tb_top: self-checking bench for the serial port in master and slave mode with a
  peer slave, several rate settings, queued bytes, overrun and mode fault.
  assumes the package register map and the one-cycle strobe register port.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  import spimsp_pkg::*;
  logic i_clk;
  logic i_sys_rst;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [DATA_W-1:0] o_rdata;
  spimsp_pins_t i_pin;
  spimsp_pins_t o_pin;
  spimsp_pins_t o_pin_oe_n;
  spimsp_pins_t o_pin_own;
  logic ss_ext;
  logic peer_miso;
  logic [7:0] peer_rx;
  logic [7:0] reply;
  logic [7:0] d;
  logic [7:0] v;
  logic [15:0] hmeas;
  logic sck_prev;
  logic sck_drv;
  logic mosi_drv;
  logic [7:0] r;
  int peer_cnt;
  int n_fail;
  int tests_run;
  int cyc;
  int lastt;
  int seed;
  int n0;
  int cp[6] = '{0, 1, 2, 7, 0, 7};
  int cr[6] = '{0, 1, 2, 0, 3, 7};
  int cl[6] = '{0, 1, 0, 1, 0, 0};
  logic [7:0] exp_q[$];

  // wire levels: an undriven pin reads the bench's own drive or the peer
  assign i_pin = {o_pin_oe_n.sck ? sck_drv : o_pin.sck, o_pin_oe_n.mosi ? mosi_drv : o_pin.mosi,
                  o_pin_oe_n.miso ? peer_miso : o_pin.miso, o_pin_oe_n.ss ? ss_ext : o_pin.ss};

  spimsp_top u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe_n(o_pin_oe_n), .o_pin_own(o_pin_own));

  spimsp_peer u_peer (.i_sck(i_pin.sck), .i_mosi(i_pin.mosi), .i_ss_n(i_pin.ss), .i_reply(reply),
    .o_miso(peer_miso), .o_rx(peer_rx), .o_cnt(peer_cnt));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev[i] = x[7-i];
  endfunction

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= x;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 x = o_rdata;
  endtask

  task automatic wait_rxf();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 20000; i++) begin
      rd(ADDR_STAT, s);
      if (s[STAT_RXF] === 1'b1) break;
    end
  endtask

  // half-period measure and hang guard; a long rate takes about 17k cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    sck_prev <= o_pin.sck;
    if (o_pin.sck !== sck_prev) begin
      hmeas <= 16'(cyc - lastt);
      lastt <= cyc;
    end
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    {i_addr, i_wdata, i_wr, i_rd, cyc, lastt, n_fail, tests_run} = '0;
    {ss_ext, sck_prev, hmeas, reply, sck_drv, mosi_drv} = {1'b1, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b1};
    seed = 34;
    i_sys_rst = 1'b1;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    `CHK(o_pin_own, 4'h0)
    `CHK(o_pin_oe_n, 4'hF)
    rd(ADDR_STAT, d);
    `CHK(d, 8'h20)
    wr(3'h6, 8'hFF);
    rd(3'h5, d);
    `CHK(d, 8'h00)
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_BAUD, {1'b0, 3'(cp[k]), 1'b0, 3'(cr[k])});
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CTRL, 8'h23 | (cl[k] ? 8'h10 : 8'h00));
      repeat (2) @(posedge i_clk);
      `CHK(o_pin_oe_n, 4'h2)
      `CHK(o_pin_own, 4'hF)
      v = 8'($random(seed));
      reply <= 8'($random(seed));
      @(posedge i_clk);
      n0 = peer_cnt;
      exp_q.push_back(cl[k] ? rev(reply ^ n0[7:0]) : reply ^ n0[7:0]);
      wr(ADDR_DATA, v);
      wait_rxf();
      rd(ADDR_DATA, d);
      `CHK(d, exp_q.pop_front())
      `CHK(peer_rx, cl[k] ? rev(v) : v)
      `CHK(hmeas, 16'((cp[k] + 1) << cr[k]))
      `CHK(o_pin.sck, 1'b0)
    end
    wr(ADDR_BAUD, 8'h01);
    n0 = peer_cnt;
    v = 8'($random(seed));
    wr(ADDR_DATA, v);
    repeat (2) @(posedge i_clk);
    rd(ADDR_STAT, d);
    `CHK(d, 8'h20)
    wr(ADDR_DATA, ~v);
    rd(ADDR_STAT, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 2000 && peer_cnt < n0 + 2; i++) @(posedge i_clk);
    repeat (6) @(posedge i_clk);
    `CHK(peer_rx, ~v)
    rd(ADDR_DATA, d);
    `CHK(d, reply ^ n0[7:0])
    rd(ADDR_STAT, d);
    `CHK(d, 8'h20)
    wr(ADDR_CTRL, 8'h03);
    ss_ext <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(ADDR_STAT, d);
    `CHK(d, 8'h30)
    rd(ADDR_CTRL, d);
    `CHK(d, 8'h01)
    ss_ext <= 1'b1;
    // slave, phase 0: the bench plays master with a half period of four clocks
    v = 8'($random(seed));
    d = 8'($random(seed));
    wr(ADDR_DATA, v);
    ss_ext <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      {sck_drv, mosi_drv} <= {1'b0, d[b]};
      repeat (4) @(posedge i_clk);
      sck_drv <= 1'b1;
      r[b] = i_pin.miso;
      repeat (4) @(posedge i_clk);
    end
    sck_drv <= 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK(o_pin_oe_n, 4'hD)
    `CHK(r, v)
    ss_ext <= 1'b1;
    rd(ADDR_DATA, v);
    `CHK(v, d)
    wr(ADDR_CTRL, 8'h00);
    repeat (2) @(posedge i_clk);
    `CHK(o_pin_own, 4'h0)
    `CHK(o_pin_oe_n, 4'hF)
    end_sim();
  end
endmodule
